/* File: dv/dic_contacts.sv */
// Contact model driving the terminal voltages
module dic_contacts #(parameter int NCH = 8)(
   input wire logic mclk,
   input wire logic [NCH*dic_pkg::VOLT_W-1:0] level,
   output logic [NCH*dic_pkg::VOLT_W-1:0] measuredVoltage
);
   timeunit 1ns;
   timeprecision 1ps;
   // Terminal settles a cycle after contacts move
   always_ff @(posedge mclk) begin
      measuredVoltage <= level;
   end
endmodule : dic_contacts

/* File: dv/dic_properties.sv */
// Port checker for the input conditioner
module dic_properties #(parameter int NCH = 8, parameter int SCAN_CNT = 10)(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [NCH-1:0] clearCounter,
   input wire logic [NCH-1:0] inputChannelState,
   input wire logic [NCH*dic_pkg::CNT_W-1:0] transitionCount,
   input wire logic [NCH*dic_pkg::VOLT_W-1:0] voltageNow,
   input wire logic scanStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [31:0] cnt0 = transitionCount[31:0];
   // Cycles since the last strobe; zero until the first one
   int gap;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gap <= 0;
      end else if (scanStrobe) begin
         gap <= 1;
      end else if (gap != 0) begin
         gap <= gap + 1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_rise0; $rose(inputChannelState[0]) && !$past(clearCounter[0]); endsequence
   sequence s_idle0; !$rose(inputChannelState[0]) && !$past(clearCounter[0]); endsequence
   a_state_on_scan: assert property (!scanStrobe |-> $stable(inputChannelState))
      else $error("state moved off scan");
   a_scan_period: assert property (gap != 0 |->
      (scanStrobe ? gap == SCAN_CNT : gap < SCAN_CNT))
      else $error("scan period wrong");
   a_scan_single: assert property (scanStrobe |=> !scanStrobe [*8])
      else $error("scan strobe repeated");
   a_count_rise: assert property (s_rise0 |-> cnt0 == $past(cnt0) + 32'h1)
      else $error("count missed a rise");
   a_count_hold: assert property (s_idle0 |-> $stable(cnt0))
      else $error("count moved without rise");
   a_count_clear: assert property (clearCounter[0] |=> cnt0 == 32'h0)
      else $error("clear ignored");
   a_count_off_scan: assert property (!scanStrobe && $past(clearCounter) == '0 |->
      $stable(transitionCount))
      else $error("counts moved off scan");
   a_volt_on_scan: assert property (!scanStrobe |-> $stable(voltageNow))
      else $error("voltage moved off scan");
endmodule : dic_properties
bind digital_input_conditioner dic_properties #(.NCH(NCH), .SCAN_CNT(SCAN_CNT))
   i_dic_properties (.mclk(mclk), .nrst(nrst), .clearCounter(clearCounter),
   .inputChannelState(inputChannelState), .transitionCount(transitionCount),
   .voltageNow(voltageNow), .scanStrobe(scanStrobe));

/* File: dv/tb_digital_input_conditioner.sv */
// Self-checking bench for the input conditioner
module tb_digital_input_conditioner;
   timeunit 1ns;
   timeprecision 1ps;
   import dic_pkg::*;
   localparam int N = 8;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic strobe;
   logic [N*VOLT_W-1:0] lvl = '0, mv, vNow;
   logic [N-1:0] inv = 8'h02, ac = '0, clr = '0, st;
   logic [N*THR_W-1:0] act = {{5{ACT_THR_RST}}, 12'h3b6, {2{ACT_THR_RST}}};
   logic [N*THR_W-1:0] rel = {N{REL_THR_RST}};
   logic [N*DLY_W-1:0] ad = '0, dd = '0;
   logic [N*CNT_W-1:0] cnt;
   int miscompares = 0, check_count = 0;
   initial forever #5 mclk = ~mclk;
   dic_contacts #(.NCH(N)) i_dic_contacts (.mclk(mclk), .level(lvl), .measuredVoltage(mv));
   digital_input_conditioner #(.NCH(N), .SCAN_CNT(10)) i_digital_input_conditioner (
      .mclk(mclk), .nrst(nrst), .measuredVoltage(mv), .polarityInv(inv),
      .actThreshold(act), .relThreshold(rel), .actDelay(ad), .dropDelay(dd),
      .alternatingSupplyOption(ac), .clearCounter(clr), .inputChannelState(st),
      .transitionCount(cnt), .voltageNow(vNow), .scanStrobe(strobe));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Realign to a scan first, so every value is seen n times
   task automatic scans(input int n, input logic [VOLT_W-1:0] v);
      @(posedge strobe) #1;
      @(posedge mclk) lvl <= {N{v}};
      repeat (n) @(posedge strobe);
      #1;
   endtask : scans
   task automatic t_levels;
      scans(2, 19'h15f90);
      chk(32'(st), 32'hf9);
      chk(32'(vNow[VOLT_W-1:0]), 32'h15f90);
      scans(2, 19'h11170);
      chk(32'(st), 32'hf9);
      scans(2, 19'h0c350);
      chk(32'(st), 32'h02);
      scans(2, 19'h15f90);
      chk(cnt[31:0], 32'h2);
      @(posedge mclk) clr <= 8'h01;
      @(posedge mclk) clr <= 8'h00;
      @(posedge mclk) #1;
      chk(cnt[31:0], 32'h0);
      chk(cnt[63:32], 32'h2);
   endtask : t_levels
   task automatic t_delays;
      @(posedge mclk);
      ad <= {N{21'h14}};
      dd <= {N{21'h14}};
      scans(2, 19'h0c350);
      scans(1, 19'h15f90);
      scans(3, 19'h0c350);
      chk(32'(st), 32'hf9);
      scans(5, 19'h0c350);
      chk(32'(st), 32'h02);
      scans(3, 19'h15f90);
      chk(32'(st), 32'h02);
      scans(5, 19'h15f90);
      chk(32'(st), 32'hf9);
   endtask : t_delays
   task automatic t_ac;
      @(posedge mclk);
      ad <= '0;
      dd <= '0;
      ac <= '1;
      scans(9, 19'h0c350);
      chk(32'(st), 32'hf9);
      scans(4, 19'h01388);
      chk(32'(st), 32'hfb);
      scans(5, 19'h01388);
      chk(32'(st), 32'h02);
   endtask : t_ac
   task automatic test_done;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      t_levels();
      t_delays();
      t_ac();
      test_done();
   end
   initial begin
      #30000;
      miscompares++;
      test_done();
   end
endmodule : tb_digital_input_conditioner

/* File: inc/dic_pkg.sv */
// Constants for the digital input conditioner
package dic_pkg;
   localparam int NUM_CH = 8;
   localparam int VOLT_W = 19;              // Millivolts, 0..275000
   localparam int THR_W = 12;               // Tenths of a volt, 0..2000
   localparam int DLY_W = 21;               // Milliseconds, 0..1800000
   localparam int CNT_W = 32;
   localparam logic [THR_W-1:0] ACT_THR_RST = 12'h370;   // 88.0 V
   localparam logic [THR_W-1:0] REL_THR_RST = 12'h258;   // 60.0 V
   localparam logic [DLY_W-1:0] DLY_MAX = 21'h1b7740;    // 1800.000 s
   localparam logic [THR_W-1:0] ACT_THR_MIN = 12'h0a0; // 16.0 V
   localparam logic [THR_W-1:0] REL_THR_MIN = 12'h064; // 10.0 V
   localparam logic [THR_W-1:0] THR_MAX = 12'h7d0; // 200.0 V
   localparam logic [VOLT_W-1:0] VOLT_MAX = 19'h43238; // 275.000 V
   localparam int CLK_HZ = 100_000_000;
   localparam int SCAN_MS = 5;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam int SCAN_CYCLES = SCAN_MS * MS_CYCLES;
   localparam int AC_DLY_MS = 30;
   localparam int MV_PER_TENTH = 100;       // Threshold unit to millivolts
endpackage : dic_pkg

/* File: src/dic_channel.sv */
// One conditioned input channel, evaluated once per scan tick
module dic_channel
   import dic_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic scanTick,
   input wire logic [VOLT_W-1:0] voltage,
   input wire logic polarityInv,
   input wire logic [THR_W-1:0] actThr,
   input wire logic [THR_W-1:0] relThr,
   input wire logic [DLY_W-1:0] actDly,
   input wire logic [DLY_W-1:0] dropDly,
   input wire logic acOption,
   input wire logic clearCount,
   output logic state,
   output logic [CNT_W-1:0] count
);
   logic energized;
   logic [DLY_W-1:0] timer;
   logic next_energized;
   logic next_state;
   logic [DLY_W-1:0] next_timer;
   logic [CNT_W-1:0] next_count;
   logic [VOLT_W+7:0] actMv;
   logic [VOLT_W+7:0] relMv;
   logic [VOLT_W+7:0] voltW;
   logic raw;
   logic [DLY_W:0] need;
   always_comb begin
      actMv = (VOLT_W+8)'(actThr) * (VOLT_W+8)'(MV_PER_TENTH);
      relMv = acOption ? (VOLT_W+8)'(actThr) * (VOLT_W+8)'(MV_PER_TENTH / 10)
                       : (VOLT_W+8)'(relThr) * (VOLT_W+8)'(MV_PER_TENTH);
      voltW = (VOLT_W+8)'(voltage);
      next_energized = energized;
      if (voltW > actMv) begin
         next_energized = 1'b1;
      end else if (voltW < relMv) begin
         next_energized = 1'b0;
      end
      // Between thresholds the previous energized level holds
      raw = next_energized ^ polarityInv;
      next_state = state;
      next_timer = timer;
      next_count = count;
      need = '0;
      if (scanTick) begin
         if (raw == state) begin
            next_timer = '0;
         end else begin
            // Delays settle on the scan grid, so they quantise to 5 ms
            need = raw ? {1'b0, actDly}
                       : {1'b0, dropDly} + (acOption ? (DLY_W+1)'(AC_DLY_MS) : '0);
            if ((DLY_W+1)'(timer) + (DLY_W+1)'(SCAN_MS) > need) begin
               next_state = raw;
               next_timer = '0;
               if (raw) begin
                  next_count = count + CNT_W'(1);
               end
            end else begin
               next_timer = timer + DLY_W'(SCAN_MS);
            end
         end
      end
      if (clearCount) begin
         next_count = '0;
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         energized <= 1'b0;
         state <= 1'b0;
         timer <= '0;
         count <= '0;
      end else begin
         energized <= scanTick ? next_energized : energized;
         state <= next_state;
         timer <= next_timer;
         count <= next_count;
      end
   end
endmodule : dic_channel

/* File: src/digital_input_conditioner.sv */
// Eight-channel digital input conditioner top
module digital_input_conditioner
#(
   parameter int NCH = dic_pkg::NUM_CH,
   parameter int SCAN_CNT = dic_pkg::SCAN_CYCLES
)(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [NCH*dic_pkg::VOLT_W-1:0] measuredVoltage,
   input wire logic [NCH-1:0] polarityInv,
   input wire logic [NCH*dic_pkg::THR_W-1:0] actThreshold,
   input wire logic [NCH*dic_pkg::THR_W-1:0] relThreshold,
   input wire logic [NCH*dic_pkg::DLY_W-1:0] actDelay,
   input wire logic [NCH*dic_pkg::DLY_W-1:0] dropDelay,
   input wire logic [NCH-1:0] alternatingSupplyOption,
   input wire logic [NCH-1:0] clearCounter,
   output logic [NCH-1:0] inputChannelState,
   output logic [NCH*dic_pkg::CNT_W-1:0] transitionCount,
   output logic [NCH*dic_pkg::VOLT_W-1:0] voltageNow,
   output logic scanStrobe
);
   import dic_pkg::*;

   // Elaboration checks: the scan grid needs at least two cycles
   if (NCH < 1) begin : g_bad_nch
      $error("digital_input_conditioner: NCH below 1");
   end
   if (SCAN_CNT < 2) begin : g_bad_scan
      $error("digital_input_conditioner: SCAN_CNT below 2");
   end

   logic [31:0] scanCnt;
   logic [31:0] next_scanCnt;
   logic scanTick;
   logic [NCH*VOLT_W-1:0] voltMeta;
   logic [NCH*VOLT_W-1:0] voltSync;
   logic [NCH*VOLT_W-1:0] next_voltageNow;
   wire [NCH*VOLT_W-1:0] voltUseAll;

   // Scan timer: one tick every SCAN_CNT cycles
   always_comb begin
      scanTick = (scanCnt == 32'(SCAN_CNT - 1));
      next_scanCnt = scanTick ? 32'h0 : scanCnt + 32'h1;
      next_voltageNow = scanTick ? voltUseAll : voltageNow;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scanCnt <= 32'h0;
         voltMeta <= '0;
         voltSync <= '0;
         voltageNow <= '0;
         scanStrobe <= 1'b0;
      end else begin
         scanCnt <= next_scanCnt;
         // Word is only synchronised here; each channel waits for it to settle
         voltMeta <= measuredVoltage;
         voltSync <= voltMeta;
         voltageNow <= next_voltageNow;
         scanStrobe <= scanTick;
      end
   end

   // Channel outputs are registered inside each channel
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [VOLT_W-1:0] vSync;
      logic [VOLT_W-1:0] vLast;
      logic [VOLT_W-1:0] vUse;
      logic [VOLT_W-1:0] next_vUse;
      logic polInv;
      logic acOn;
      logic [THR_W-1:0] actSet;
      logic [THR_W-1:0] relSet;
      logic [DLY_W-1:0] actDlySet;
      logic [DLY_W-1:0] dropDlySet;
      logic [THR_W-1:0] next_actSet;
      logic [THR_W-1:0] next_relSet;
      logic [DLY_W-1:0] next_actDlySet;
      logic [DLY_W-1:0] next_dropDlySet;

      assign vSync = voltSync[i*VOLT_W +: VOLT_W];
      assign voltUseAll[i*VOLT_W +: VOLT_W] = vUse;

      // Settings clamped to their legal ranges before use
      always_comb begin
         next_actSet = actThreshold[i*THR_W +: THR_W];
         if (next_actSet > THR_MAX) begin
            next_actSet = THR_MAX;
         end else if (next_actSet < ACT_THR_MIN) begin
            next_actSet = ACT_THR_MIN;
         end

         next_relSet = relThreshold[i*THR_W +: THR_W];
         if (next_relSet > THR_MAX) begin
            next_relSet = THR_MAX;
         end else if (next_relSet < REL_THR_MIN) begin
            next_relSet = REL_THR_MIN;
         end

         next_actDlySet = actDelay[i*DLY_W +: DLY_W];
         if (next_actDlySet > DLY_MAX) begin
            next_actDlySet = DLY_MAX;
         end

         next_dropDlySet = dropDelay[i*DLY_W +: DLY_W];
         if (next_dropDlySet > DLY_MAX) begin
            next_dropDlySet = DLY_MAX;
         end

         // Taken only after two equal samples; a reading that never holds is missed
         next_vUse = vUse;
         if (vSync == vLast) begin
            if (vSync > VOLT_MAX) begin
               next_vUse = VOLT_MAX;
            end else begin
               next_vUse = vSync;
            end
         end
      end

      always_ff @(posedge mclk or negedge nrst) begin
         if (!nrst) begin
            polInv <= 1'b0;
            acOn <= 1'b0;
            actSet <= ACT_THR_RST;
            relSet <= REL_THR_RST;
            actDlySet <= '0;
            dropDlySet <= '0;
            vLast <= '0;
            vUse <= '0;
         end else begin
            polInv <= polarityInv[i];
            acOn <= alternatingSupplyOption[i];
            actSet <= next_actSet;
            relSet <= next_relSet;
            actDlySet <= next_actDlySet;
            dropDlySet <= next_dropDlySet;
            vLast <= vSync;
            vUse <= next_vUse;
         end
      end

      dic_channel i_dic_channel (
         .mclk(mclk),
         .nrst(nrst),
         .scanTick(scanTick),
         .voltage(vUse),
         .polarityInv(polInv),
         .actThr(actSet),
         .relThr(relSet),
         .actDly(actDlySet),
         .dropDly(dropDlySet),
         .acOption(acOn),
         .clearCount(clearCounter[i]),
         .state(inputChannelState[i]),
         .count(transitionCount[i*CNT_W +: CNT_W])
      );
   end
endmodule : digital_input_conditioner
